// File: pcct_consts.svh
// Named offsets, field positions, reset values and clock counts for the card cycle generator.
`ifndef PCCT_CONSTS_SVH
`define PCCT_CONSTS_SVH

// ************************************************************
// Register byte offsets on the Wishbone slave.
// ************************************************************
`define PCCT_OFS_S0_MEM  8'h00
`define PCCT_OFS_S0_IO   8'h04
`define PCCT_OFS_S1_MEM  8'h08
`define PCCT_OFS_S1_IO   8'h0c
`define PCCT_OFS_STATUS  8'h10
`define PCCT_CFG_SPAN    8'h10

// ************************************************************
// Field positions and reset values.
// ************************************************************
`define PCCT_CFG_WS_LSB  0
`define PCCT_CFG_WS_MSB  1
`define PCCT_CFG_ZWS     2
`define PCCT_CFG_TS_LSB  4
`define PCCT_CFG_TS_MSB  5
`define PCCT_CFG_RST     8'h10
`define PCCT_CFG_MASK    8'h37
`define PCCT_ADR_SOCK    3
`define PCCT_ADR_IO      2
`define PCCT_STS_BUSY    0
`define PCCT_STS_LAST_LSB 8
`define PCCT_STS_LAST_MSB 15

// ************************************************************
// Clock counts of the card cycle phases.
// ************************************************************
`define PCCT_SU_IO        8'h03
`define PCCT_SU_MEM_LO    8'h02
`define PCCT_SU_MEM_HI    8'h04
`define PCCT_ACT8_NORM    8'h13
`define PCCT_ACT8_WAIT    8'h17
`define PCCT_ACT8_ZWS     8'h07
`define PCCT_ACT16_IO_LO  8'h07
`define PCCT_ACT16_IO_HI  8'h0b
`define PCCT_ACT16_M0     8'h09
`define PCCT_ACT16_M1     8'h0d
`define PCCT_ACT16_M2     8'h11
`define PCCT_ACT16_M3     8'h17
`define PCCT_ACT16_M_ZWS  8'h05
`define PCCT_HOLD_LO      8'h02
`define PCCT_HOLD_HI      8'h03

`endif

// File: pcct_pkg.sv
// Types shared by the card cycle generator modules.
package pcct_pkg;
    typedef enum logic [2:0] {
        PCCT_IDLE,
        PCCT_SETUP,
        PCCT_ACTIVE,
        PCCT_HOLD
    } pcct_state_type;
endpackage : pcct_pkg

// File: pcct_sync2.sv
// Two-stage synchroniser for inputs arriving from the card pins.
module pcct_sync2 import pcct_pkg::*; #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;

    // ************************************************************
    // Synchroniser stages.
    // ************************************************************

    // The first stage feeds only the second, so metastability never reaches logic.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            meta_reg <= RST_VAL;
            o_sync   <= RST_VAL;
        end else begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end
endmodule : pcct_sync2

// File: pcct_down_counter.sv
// Loadable down counter that times one phase of a card cycle in whole clocks.
module pcct_down_counter import pcct_pkg::*; #(
    parameter int WIDTH = 8
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    input  wire logic             i_load,
    input  wire logic [WIDTH-1:0] i_value,
    output logic                  o_zero
);
    logic [WIDTH-1:0] cnt_reg;

    // ************************************************************
    // Counter.
    // ************************************************************

    // Loading N-1 makes a phase that waits for zero last exactly N clocks.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cnt_reg <= '0;
        end else if (i_load) begin
            cnt_reg <= i_value;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    assign o_zero = (cnt_reg == '0);
endmodule : pcct_down_counter

// File: pcct_cycle_gen.sv
// Card cycle generator: sequences address setup, command and hold for a 16-bit card socket.
//
// What this block does
// RULE1: Command length, and memory setup and hold, are looked up from the wait settings of the addressed socket's memory or I/O window.
// RULE2: Setup, command and hold phases are timed by counting whole clocks.
// RULE3: Each phase length equals or slightly exceeds the legacy controller timing and never falls short.
// RULE4: Address setup is 3 clocks for I/O, 2 for memory with the upper wait bit clear and 4 with it set.
// RULE5: 8-bit I/O command lasts 19 clocks, 23 with the wait bit set and 7 with only zero-wait set.
// RULE6: 8-bit memory command lasts 19 clocks for wait field 00, 23 for 01, 10 or 11, and 7 for 00 with zero-wait.
// RULE7: 16-bit I/O command lasts 7 clocks, 11 with the wait bit, and zero-wait never shortens it.
// RULE8: 16-bit memory command lasts 9, 13, 17 or 23 clocks for wait field 00 to 11, and 5 for 00 with zero-wait.
// RULE9: Address hold is 2 clocks for I/O, 2 for memory with the upper wait bit clear and 3 with it set.
// RULE10: While the card holds its wait line low the command is extended past its programmed minimum.
// RULE11: A cycle drives address and enables, counts setup, asserts the command, deasserts it, counts hold, releases.
`include "pcct_consts.svh"

module pcct_cycle_gen import pcct_pkg::*; #(
    parameter int NUM_SOCKETS = 2,
    parameter int CNT_W       = 8
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // Wishbone slave.
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    // Internal request side.
    input  wire logic        i_req_valid,
    input  wire logic        i_req_socket,
    input  wire logic        i_req_mem,
    input  wire logic        i_req_wide,
    input  wire logic        i_req_write,
    input  wire logic        i_req_attr,
    input  wire logic [25:0] i_req_addr,
    input  wire logic [15:0] i_req_wdata,
    output logic             o_req_ready,
    output logic             o_req_done,
    output logic      [15:0] o_req_rdata,
    // Card side.
    output logic      [25:0] o_card_addr,
    output logic             o_card_reg_n,
    output logic             o_card_ce1_n,
    output logic             o_card_ce2_n,
    output logic             o_card_oe_n,
    output logic             o_card_we_n,
    output logic             o_card_iord_n,
    output logic             o_card_iowr_n,
    input  wire logic [15:0] i_card_data,
    output logic      [15:0] o_card_data,
    output logic             o_card_data_oe_n,
    input  wire logic        i_card_wait_n
);
    // ************************************************************
    // Parameter checks.
    // ************************************************************
    if (NUM_SOCKETS < 1 || NUM_SOCKETS > 2) begin : g_bad_sockets
        $error("NUM_SOCKETS must be 1 or 2");
    end
    if (CNT_W < 5) begin : g_bad_cnt
        $error("CNT_W must hold a count of 23");
    end

    // ************************************************************
    // Declarations.
    // ************************************************************
    logic [7:0]     cfg_reg [2*NUM_SOCKETS];
    pcct_state_type state_reg;
    logic           mem_reg;
    logic           write_reg;
    logic [7:0]     act_cnt_reg;
    logic [7:0]     hold_cnt_reg;
    logic [7:0]     last_act_reg;
    logic [7:0]     act_meas_reg;
    logic [7:0]     sel_cfg;
    logic [7:0]     su_cnt;
    logic [7:0]     act_cnt;
    logic [7:0]     hold_cnt;
    logic [1:0]     ws_field;
    logic           zws_bit;
    logic           wait_n_sync;
    logic [15:0]    data_sync;
    logic           cnt_load;
    logic [CNT_W-1:0] cnt_value;
    logic           cnt_zero;
    logic           take_req;
    logic           wb_req;
    logic           cfg_hit;
    logic [7:0]     status_low;
    logic [1:0]     cfg_idx;

    // ************************************************************
    // Card input synchronisers.
    // ************************************************************

    // The wait line is a pin, so it is resynchronised before the sequencer reads it.
    pcct_sync2 #(
        .WIDTH   (1),
        .RST_VAL (1'b1)
    ) u_wait_sync (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_async (i_card_wait_n),
        .o_sync  (wait_n_sync)
    );

    // Read data is sampled two clocks late, which still falls inside the command.
    pcct_sync2 #(
        .WIDTH   (16),
        .RST_VAL (16'h0000)
    ) u_data_sync (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_async (i_card_data),
        .o_sync  (data_sync)
    );

    // ************************************************************
    // Wishbone slave.
    // ************************************************************
    assign wb_req  = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    assign cfg_hit = (i_wb_adr < `PCCT_CFG_SPAN) &&
                     (int'(i_wb_adr[`PCCT_ADR_SOCK]) < NUM_SOCKETS) &&
                     (i_wb_adr[1:0] == 2'b00);
    assign cfg_idx = {i_wb_adr[`PCCT_ADR_SOCK], i_wb_adr[`PCCT_ADR_IO]};
    assign status_low = {7'h00, (state_reg != PCCT_IDLE)};

    // Ack comes one clock after the strobe and drops in the next; unmapped reads give zero.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= wb_req;
            o_wb_dat <= 32'h0000_0000;
            if (wb_req && !i_wb_we) begin
                if (cfg_hit) begin
                    o_wb_dat <= {24'h00_0000, cfg_reg[cfg_idx]};
                end else if (i_wb_adr == `PCCT_OFS_STATUS) begin
                    o_wb_dat <= {16'h0000, last_act_reg, status_low};
                end
            end
        end
    end

    // Window wait settings; only the low byte lane carries fields, reserved bits stay zero.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            for (int i = 0; i < 2*NUM_SOCKETS; i++) begin
                cfg_reg[i] <= `PCCT_CFG_RST;
            end
        end else if (wb_req && i_wb_we && cfg_hit && i_wb_sel[0]) begin
            cfg_reg[cfg_idx] <= i_wb_dat[7:0] & `PCCT_CFG_MASK;
        end
    end

    // ************************************************************
    // Timing lookup.
    // ************************************************************

    // The timing select field has one documented setting; every value uses that table.
    always_comb begin
        sel_cfg  = cfg_reg[(NUM_SOCKETS > 1) ? {i_req_socket, ~i_req_mem} : {1'b0, ~i_req_mem}]; // [RULE1]
        ws_field = sel_cfg[`PCCT_CFG_WS_MSB:`PCCT_CFG_WS_LSB];
        zws_bit  = sel_cfg[`PCCT_CFG_ZWS];
        if (!i_req_mem) begin
            su_cnt   = `PCCT_SU_IO;   // [RULE4]
            hold_cnt = `PCCT_HOLD_LO; // [RULE9]
            if (!i_req_wide) begin
                if (ws_field[0]) begin
                    act_cnt = `PCCT_ACT8_WAIT; // [RULE5]
                end else if (zws_bit) begin
                    act_cnt = `PCCT_ACT8_ZWS;  // [RULE5]
                end else begin
                    act_cnt = `PCCT_ACT8_NORM; // [RULE5]
                end
            end else begin
                // Zero-wait is ignored here on purpose.
                act_cnt = ws_field[0] ? `PCCT_ACT16_IO_HI : `PCCT_ACT16_IO_LO; // [RULE7]
            end
        end else begin
            su_cnt   = ws_field[1] ? `PCCT_SU_MEM_HI : `PCCT_SU_MEM_LO; // [RULE4]
            hold_cnt = ws_field[1] ? `PCCT_HOLD_HI : `PCCT_HOLD_LO;     // [RULE9]
            if (!i_req_wide) begin
                if (ws_field != 2'b00) begin
                    act_cnt = `PCCT_ACT8_WAIT; // [RULE6]
                end else if (zws_bit) begin
                    act_cnt = `PCCT_ACT8_ZWS;  // [RULE6]
                end else begin
                    act_cnt = `PCCT_ACT8_NORM; // [RULE6]
                end
            end else begin
                case (ws_field)
                    2'b00: act_cnt = zws_bit ? `PCCT_ACT16_M_ZWS : `PCCT_ACT16_M0; // [RULE8]
                    2'b01: act_cnt = `PCCT_ACT16_M1; // [RULE8]
                    2'b10: act_cnt = `PCCT_ACT16_M2; // [RULE8]
                    // The printed entry disagrees with itself; the longer count cannot fall short.
                    2'b11: act_cnt = `PCCT_ACT16_M3; // [RULE8] [RULE3]
                    default: act_cnt = `PCCT_ACT16_M3;
                endcase
            end
        end
    end

    // ************************************************************
    // Phase counter.
    // ************************************************************
    assign take_req = (state_reg == PCCT_IDLE) && i_req_valid;

    // Each phase loads its count minus one so setup and hold span exactly that many clocks and the command at least that many.
    always_comb begin
        cnt_load  = 1'b0;
        cnt_value = '0;
        case (state_reg)
            PCCT_IDLE: begin
                cnt_load  = take_req;
                cnt_value = CNT_W'(su_cnt - 8'h01); // [RULE2]
            end
            PCCT_SETUP: begin
                cnt_load  = cnt_zero;
                cnt_value = CNT_W'(act_cnt_reg - 8'h01); // [RULE2]
            end
            PCCT_ACTIVE: begin
                cnt_load  = cnt_zero && wait_n_sync;
                cnt_value = CNT_W'(hold_cnt_reg - 8'h01); // [RULE2]
            end
            default: begin
                cnt_load  = 1'b0;
                cnt_value = '0;
            end
        endcase
    end

    pcct_down_counter #(
        .WIDTH   (CNT_W)
    ) u_phase_cnt (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_load  (cnt_load),
        .i_value (cnt_value),
        .o_zero  (cnt_zero)
    );

    // ************************************************************
    // Cycle sequencer.
    // ************************************************************

    // Phase order is fixed; the command only ends once the count is out and the card is ready.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state_reg    <= PCCT_IDLE;
            mem_reg      <= 1'b0;
            write_reg    <= 1'b0;
            act_cnt_reg  <= `PCCT_ACT8_NORM;
            hold_cnt_reg <= `PCCT_HOLD_LO;
        end else begin
            case (state_reg)
                PCCT_IDLE: begin
                    if (take_req) begin
                        state_reg    <= PCCT_SETUP; // [RULE11]
                        mem_reg      <= i_req_mem;
                        write_reg    <= i_req_write;
                        act_cnt_reg  <= act_cnt;
                        hold_cnt_reg <= hold_cnt;
                    end
                end
                PCCT_SETUP: begin
                    if (cnt_zero) begin
                        state_reg <= PCCT_ACTIVE; // [RULE11]
                    end
                end
                PCCT_ACTIVE: begin
                    if (cnt_zero && wait_n_sync) begin
                        state_reg <= PCCT_HOLD; // [RULE10] [RULE11]
                    end
                end
                PCCT_HOLD: begin
                    if (cnt_zero) begin
                        state_reg <= PCCT_IDLE; // [RULE11]
                    end
                end
                default: state_reg <= PCCT_IDLE;
            endcase
        end
    end

    // Address, attribute select, enables and write data are set up at acceptance; attribute select, enables and data drive are released after hold.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_card_addr      <= 26'h000_0000;
            o_card_reg_n     <= 1'b1;
            o_card_ce1_n     <= 1'b1;
            o_card_ce2_n     <= 1'b1;
            o_card_data      <= 16'h0000;
            o_card_data_oe_n <= 1'b1;
        end else if (take_req) begin
            o_card_addr      <= i_req_addr; // [RULE11]
            o_card_reg_n     <= ~i_req_attr;
            o_card_ce1_n     <= 1'b0;
            o_card_ce2_n     <= ~i_req_wide;
            o_card_data      <= i_req_wdata;
            o_card_data_oe_n <= ~i_req_write;
        end else if (state_reg == PCCT_HOLD && cnt_zero) begin
            o_card_reg_n     <= 1'b1; // [RULE11]
            o_card_ce1_n     <= 1'b1;
            o_card_ce2_n     <= 1'b1;
            o_card_data_oe_n <= 1'b1;
        end
    end

    // Command strobe: low from the end of setup until the extended active count has run out.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_card_oe_n   <= 1'b1;
            o_card_we_n   <= 1'b1;
            o_card_iord_n <= 1'b1;
            o_card_iowr_n <= 1'b1;
        end else if (state_reg == PCCT_SETUP && cnt_zero) begin
            o_card_oe_n   <= ~(mem_reg & ~write_reg);
            o_card_we_n   <= ~(mem_reg & write_reg);
            o_card_iord_n <= ~(~mem_reg & ~write_reg);
            o_card_iowr_n <= ~(~mem_reg & write_reg);
        end else if (state_reg == PCCT_ACTIVE && cnt_zero && wait_n_sync) begin
            o_card_oe_n   <= 1'b1; // [RULE10]
            o_card_we_n   <= 1'b1;
            o_card_iord_n <= 1'b1;
            o_card_iowr_n <= 1'b1;
        end
    end

    // ************************************************************
    // Request answer and status.
    // ************************************************************

    // Ready is registered so it drops in the clock after a request is taken.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_req_ready <= 1'b1;
            o_req_done  <= 1'b0;
            o_req_rdata <= 16'h0000;
        end else begin
            o_req_done <= (state_reg == PCCT_HOLD) && cnt_zero;
            if (take_req) begin
                o_req_ready <= 1'b0;
            end else if (state_reg == PCCT_HOLD && cnt_zero) begin
                o_req_ready <= 1'b1;
            end
            if (state_reg == PCCT_ACTIVE && cnt_zero && wait_n_sync && !write_reg) begin
                o_req_rdata <= data_sync;
            end
        end
    end

    // Measured command length saturates, so long wait extensions read as the maximum.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            act_meas_reg <= 8'h00;
            last_act_reg <= 8'h00;
        end else if (state_reg == PCCT_SETUP) begin
            act_meas_reg <= 8'h01;
        end else if (state_reg == PCCT_ACTIVE) begin
            if (cnt_zero && wait_n_sync) begin
                last_act_reg <= act_meas_reg;
            end else if (act_meas_reg != 8'hff) begin
                act_meas_reg <= act_meas_reg + 8'h01;
            end
        end
    end
endmodule : pcct_cycle_gen

// File: pcct_cycle_gen_props.sv
// Concurrent checks on the card-side phase timing of the cycle generator.
module pcct_cycle_gen_props import pcct_pkg::*; (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic o_req_ready,
    input wire logic o_req_done,
    input wire logic o_card_ce1_n,
    input wire logic o_card_oe_n,
    input wire logic o_card_we_n,
    input wire logic o_card_iord_n,
    input wire logic o_card_iowr_n,
    input wire logic i_card_wait_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********
    // Command strobes seen as active-high levels.
    // ********
    wire mcmd = !o_card_oe_n || !o_card_we_n;
    wire icmd = !o_card_iord_n || !o_card_iowr_n;
    wire cmd  = mcmd || icmd;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // The card enable o_card_ce1_n stays low for the two hold clocks after a command.
    sequence s_hold2;
        !o_card_ce1_n [*2];
    endsequence
    // A wait seen during a command that is still running two clocks later.
    sequence s_wait_seen;
        !i_card_wait_n && cmd ##2 cmd;
    endsequence
    property p_one_cmd;
        $onehot0({mcmd && !o_card_oe_n, !o_card_we_n, !o_card_iord_n, !o_card_iowr_n});
    endproperty
    property p_cmd_framed;
        cmd |-> !o_card_ce1_n && !o_req_ready;
    endproperty
    property p_io_setup;
        $rose(icmd) |-> $past(o_card_ce1_n, 4) && !$past(o_card_ce1_n, 3);
    endproperty
    property p_mem_setup;
        $rose(mcmd) |-> !$past(o_card_ce1_n, 2) && ($past(o_card_ce1_n, 3)
            || $past(o_card_ce1_n, 5) && !$past(o_card_ce1_n, 4));
    endproperty
    property p_io_hold;
        $fell(icmd) |-> s_hold2 ##1 o_card_ce1_n;
    endproperty
    property p_mem_hold;
        $fell(mcmd) |-> s_hold2 ##[1:2] o_card_ce1_n;
    endproperty
    property p_cmd_min;
        $rose(cmd) |-> cmd [*5];
    endproperty
    property p_wait_ext;
        s_wait_seen |=> cmd;
    endproperty
    property p_done_idle;
        o_req_done |-> o_req_ready && o_card_ce1_n;
    endproperty
    a_one_cmd: assert property (p_one_cmd) else $error("two command strobes low together");
    a_cmd_framed: assert property (p_cmd_framed) else $error("command outside a cycle");
    a_io_setup: assert property (p_io_setup) else $error("io setup length wrong");
    a_mem_setup: assert property (p_mem_setup) else $error("memory setup length wrong");
    a_io_hold: assert property (p_io_hold) else $error("io hold length wrong");
    a_mem_hold: assert property (p_mem_hold) else $error("memory hold length wrong");
    a_cmd_min: assert property (p_cmd_min) else $error("command shorter than five clocks");
    a_wait_ext: assert property (p_wait_ext) else $error("command ended during wait");
    a_done_idle: assert property (p_done_idle) else $error("done while card enabled");
endmodule : pcct_cycle_gen_props

bind pcct_cycle_gen pcct_cycle_gen_props i_pcct_cycle_gen_props (.i_mclk, .i_rst, .o_req_ready,
    .o_req_done, .o_card_ce1_n, .o_card_oe_n, .o_card_we_n, .o_card_iord_n, .o_card_iowr_n, .i_card_wait_n);

// File: pcct_card_model.sv
// Behavioural model of a 16-bit memory or I/O card on the socket.
module pcct_card_model import pcct_pkg::*; (
    input  wire logic        i_mclk,
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    input  wire logic        i_iord_n,
    input  wire logic        i_iowr_n,
    input  wire logic        i_doe_n,
    input  wire logic [15:0] i_addr,
    input  wire logic [15:0] i_data,
    input  wire logic [7:0]  i_ext,
    output logic      [15:0] o_data,
    output logic             o_wait_n,
    output logic      [15:0] o_wr_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  k    = 8'h00;
    logic [15:0] last = 16'h0000;
    wire         rd   = !i_oe_n || !i_iord_n;
    wire         wr   = !i_we_n || !i_iowr_n;
    // Outside a read the bus toggles every clock, so a stale value can never pass as read data.
    assign o_data = rd ? i_addr ^ 16'h5a5a : ~last;
    // Wait is held for the first i_ext clocks of a command; it idles high on its pull-up.
    assign o_wait_n = !((rd || wr) && k < i_ext);
    // Clock counter within the command, and capture of written data while the cycle generator drives.
    always_ff @(posedge i_mclk) begin
        last <= o_data;
        k <= (rd || wr) ? k + 8'h01 : 8'h00;
        if (wr && !i_doe_n) o_wr_data <= i_data;
    end
endmodule : pcct_card_model

// File: tb.sv
// Self-checking bench for the card cycle generator.
module tb import pcct_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_mclk = 1'b0;
    logic        i_rst  = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00, ext = 8'h00;
    logic [31:0] wdat = 32'h0, rd, wb_q, lfsr = 32'h64b4;
    logic        rv = 1'b0, rs = 1'b0, rm = 1'b0, rwide = 1'b0, rwr = 1'b0, ra = 1'b0;
    logic [25:0] raddr = 26'h0, caddr;
    logic [15:0] rwd = 16'h0, rdat, cdi, cdo, mwd;
    logic        ack, rdy, done, reg_n, ce1, ce2, oe, wen, iord, iowr, doe, wait_n;
    int          n_errors = 0, n_tests = 0;
    wire         cmdl = !(oe && wen && iord && iowr);
    always #5 i_mclk = ~i_mclk;
    pcct_cycle_gen i_pcct_cycle_gen (.i_mclk(i_mclk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wdat), .o_wb_dat(wb_q), .o_wb_ack(ack),
        .i_req_valid(rv), .i_req_socket(rs), .i_req_mem(rm), .i_req_wide(rwide), .i_req_write(rwr),
        .i_req_attr(ra), .i_req_addr(raddr), .i_req_wdata(rwd), .o_req_ready(rdy), .o_req_done(done),
        .o_req_rdata(rdat), .o_card_addr(caddr), .o_card_reg_n(reg_n), .o_card_ce1_n(ce1),
        .o_card_ce2_n(ce2), .o_card_oe_n(oe), .o_card_we_n(wen), .o_card_iord_n(iord),
        .o_card_iowr_n(iowr), .i_card_data(cdi), .o_card_data(cdo), .o_card_data_oe_n(doe),
        .i_card_wait_n(wait_n));
    pcct_card_model i_pcct_card_model (.i_mclk(i_mclk), .i_oe_n(oe), .i_we_n(wen), .i_iord_n(iord),
        .i_iowr_n(iowr), .i_doe_n(doe), .i_addr(caddr[15:0]), .i_data(cdo), .i_ext(ext), .o_data(cdi),
        .o_wait_n(wait_n), .o_wr_data(mwd));
    // ********
    // Reference model and shared tasks.
    // ********
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt
    // Command length: c[0] memory, c[1] wide, c[3:2] wait field, c[4] zero-wait.
    function automatic int act(input logic [4:0] c);
        if (!c[1]) return (c[0] ? c[3:2] != 2'b00 : c[2]) ? 23 : c[4] ? 7 : 19;
        if (!c[0]) return c[2] ? 11 : 7;
        if (c[3:2] == 2'b00) return c[4] ? 5 : 9;
        return c[3] ? (c[2] ? 23 : 17) : 13;
    endfunction : act
    task automatic chk(input string nm, input int e, input logic [31:0] g);
        n_tests++;
        if (g !== 32'(e)) begin
            n_errors++;
            $display("unexpected %s: expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    // Classic single Wishbone cycle; data is taken at the edge that samples ack high.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge i_mclk); while (ack !== 1'b1);
        rd = wb_q;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    // Program one window, run one card cycle and measure its phases on the pins.
    task automatic run(input logic [4:0] c, input int e);
        logic [7:0]  cfg;
        logic [7:0]  wa;
        logic [15:0] msk, en;
        int          s, ac, h, ea;
        lfsr = nxt(lfsr);
        cfg = {4'h1, 1'b0, c[4], c[3:2]};
        wa = {4'h0, lfsr[9], !c[0], 2'b00};
        msk = c[1] ? 16'hffff : 16'h00ff;
        wb(1'b1, wa, {24'h0, cfg});
        wb(1'b0, wa, 32'h0);
        chk("window", cfg, rd);
        ext <= 8'(e);
        rv <= 1'b1;
        rs <= lfsr[9];
        rm <= c[0];
        rwide <= c[1];
        rwr <= lfsr[6];
        ra <= lfsr[7];
        raddr <= lfsr[25:0];
        rwd <= lfsr[31:16];
        @(posedge i_mclk);
        rv <= 1'b0;
        s = 0;
        ac = 0;
        h = 0;
        while (done !== 1'b1) begin
            @(posedge i_mclk);
            if (ce1 === 1'b0) en = {reg_n, ce2};
            if (ce1 === 1'b0 && cmdl) ac++;
            else if (ce1 === 1'b0 && ac == 0) s++;
            else if (ce1 === 1'b0) h++;
        end
        ea = act(c) > e + 3 ? act(c) : e + 3;
        chk("setup", !c[0] ? 3 : c[3] ? 4 : 2, 32'(s));
        chk("active", ea, 32'(ac));
        chk("hold", c[0] && c[3] ? 3 : 2, 32'(h));
        chk("enables", {!ra, !rwide}, en);
        if (lfsr[6]) chk("write data", lfsr[31:16] & msk, {16'h0, mwd & msk});
        else chk("read data", (lfsr[15:0] ^ 16'h5a5a) & msk, {16'h0, rdat & msk});
        wb(1'b0, 8'h10, 32'h0);
        chk("length", ea, {24'h0, rd[15:8]});
        $display("cycle %h ext %0d finished", c, e);
    endtask : run
    // Main sequence: reset values, every window wait setting, then card-held waits.
    initial begin
        repeat (3) @(posedge i_mclk);
        i_rst <= 1'b0;
        wb(1'b0, 8'h00, 32'h0);
        chk("window reset", 32'h10, rd);
        wb(1'b0, 8'h14, 32'h0);
        chk("unmapped", 0, rd);
        for (int i = 0; i < 32; i++) run(5'(i), 0);
        for (int i = 0; i < 4; i++) run(5'(i * 5 + 3), 14 + i * 4);
        stop_test();
    end
    // A cycle takes under 100 clocks; 100 us only runs out on a hang.
    initial begin
        #100000;
        n_errors++;
        stop_test();
    end
endmodule : tb
